// file: fsfc_top.sv
// fsfc_top: frame sync pulse generator and csi-2 frame number counter
// assumes: synchronous reset, axi4-lite master holds payload until taken,
// frame start/end strobes come from the frame builder in the same clock.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fsfc_top
  import fsfc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire logic              i_frame_start,
  input  wire logic              i_frame_end,
  output logic                   o_camera_trigger_pulse,
  output fsfc_frame_tag_type     o_frame_tag
);

  logic [7:0]         sync_high_upper;
  logic [7:0]         sync_high_lower;
  logic [7:0]         sync_low_upper;
  logic [7:0]         sync_low_lower;
  logic [7:0]         frame_limit_upper_byte;
  logic [7:0]         frame_limit_lower_byte;
  fsfc_ctrl_type      ctrl;
  logic [ADDR_W-1:0]  aw_addr;
  logic               aw_held;
  logic [31:0]        w_data;
  logic               w_held;
  logic               w_lane0;
  fsfc_gen_state_type gen_state;
  logic [23:0]        period_cnt;
  logic [15:0]        frame_number;
  logic [15:0]        sync_high_count;
  logic [15:0]        sync_low_count;
  logic [23:0]        shared_period;
  logic [15:0]        frame_limit;
  logic [23:0]        high_reload;
  logic [23:0]        low_reload;
  logic               do_write;
  logic [7:0]         wr_idx;

  // byte word index from a byte address; low two bits are the lane offset
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx >= IDX_SYNC_CTRL) && (idx <= IDX_FRAME_LIM_LOWER);
  endfunction : mapped

  // control fields by bit position, so reset, write and read agree on the layout
  function automatic fsfc_ctrl_type ctrl_decode(input logic [7:0] b);
    ctrl_decode.sync_generator_on = b[CTRL_GEN_ON_BIT];
    ctrl_decode.sync_shape_select = b[CTRL_SHAPE_BIT];
    ctrl_decode.sync_start_level  = b[CTRL_START_BIT];
    ctrl_decode.raw_mode          = b[CTRL_RAW_MODE_BIT];
  endfunction : ctrl_decode

  // a number past the limit (limit lowered mid-run) also wraps back to one
  function automatic logic [15:0] next_frame(input logic [15:0] cur,
                                             input logic [15:0] lim);
    next_frame = (cur >= lim || cur == 16'h0000) ? 16'h0001 : cur + 16'h0001;
  endfunction : next_frame

  assign sync_high_count = {sync_high_upper, sync_high_lower};
  assign sync_low_count  = {sync_low_upper, sync_low_lower};
  assign shared_period   = {sync_high_lower, sync_low_upper, sync_low_lower};
  assign frame_limit     = {frame_limit_upper_byte, frame_limit_lower_byte};
  assign high_reload = ctrl.sync_shape_select ? shared_period : {8'h00, sync_high_count};
  assign low_reload  = ctrl.sync_shape_select ? shared_period : {8'h00, sync_low_count};

  // write channel: address and data latched independently, in either order
  assign do_write = aw_held && w_held && !o_bvalid;
  assign wr_idx   = word_index(aw_addr);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      aw_held   <= 1'b0;
      aw_addr   <= '0;
      o_awready <= 1'b0;
    end else begin
      o_awready <= 1'b0;
      if (do_write) begin
        aw_held <= 1'b0;
      end else if (i_awvalid && !aw_held && !o_awready) begin
        o_awready <= 1'b1;
      end
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      w_held   <= 1'b0;
      w_data   <= '0;
      w_lane0  <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_wready <= 1'b0;
      if (do_write) begin
        w_held <= 1'b0;
      end else if (i_wvalid && !w_held && !o_wready) begin
        o_wready <= 1'b1;
      end
      if (i_wvalid && o_wready) begin
        w_held  <= 1'b1;
        w_data  <= i_wdata;
        w_lane0 <= i_wstrb[0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // registers live in byte lane 0; a write without that strobe changes nothing
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync_high_upper        <= RST_SYNC_HIGH_UPPER;
      sync_high_lower        <= RST_SYNC_HIGH_LOWER;
      sync_low_upper         <= RST_SYNC_LOW_UPPER;
      sync_low_lower         <= RST_SYNC_LOW_LOWER;
      frame_limit_upper_byte <= RST_FRAME_LIM_UPPER;
      frame_limit_lower_byte <= RST_FRAME_LIM_LOWER;
      ctrl                   <= ctrl_decode(RST_SYNC_CTRL);
    end else if (do_write && w_lane0) begin
      case (wr_idx)
        IDX_SYNC_HIGH_UPPER: sync_high_upper        <= w_data[7:0];
        IDX_SYNC_HIGH_LOWER: sync_high_lower        <= w_data[7:0];
        IDX_SYNC_LOW_UPPER:  sync_low_upper         <= w_data[7:0];
        IDX_SYNC_LOW_LOWER:  sync_low_lower         <= w_data[7:0];
        IDX_FRAME_LIM_UPPER: frame_limit_upper_byte <= w_data[7:0];
        IDX_FRAME_LIM_LOWER: frame_limit_lower_byte <= w_data[7:0];
        IDX_SYNC_CTRL:       ctrl                   <= ctrl_decode(w_data[7:0]);
        default: ;
      endcase
    end
  end

  // read channel: one read at a time, answer one edge after the address is taken
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end else begin
      o_arready <= 1'b0;
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
      if (i_arvalid && !o_arready && !o_rvalid) begin
        o_arready <= 1'b1;
      end
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= RESP_OKAY;
        o_rdata  <= '0;
        case (word_index(i_araddr))
          IDX_SYNC_HIGH_UPPER: o_rdata[7:0] <= sync_high_upper;
          IDX_SYNC_HIGH_LOWER: o_rdata[7:0] <= sync_high_lower;
          IDX_SYNC_LOW_UPPER:  o_rdata[7:0] <= sync_low_upper;
          IDX_SYNC_LOW_LOWER:  o_rdata[7:0] <= sync_low_lower;
          IDX_FRAME_LIM_UPPER: o_rdata[7:0] <= frame_limit_upper_byte;
          IDX_FRAME_LIM_LOWER: o_rdata[7:0] <= frame_limit_lower_byte;
          IDX_SYNC_CTRL: begin
            o_rdata[CTRL_GEN_ON_BIT]   <= ctrl.sync_generator_on;
            o_rdata[CTRL_SHAPE_BIT]    <= ctrl.sync_shape_select;
            o_rdata[CTRL_START_BIT]    <= ctrl.sync_start_level;
            o_rdata[CTRL_RAW_MODE_BIT] <= ctrl.raw_mode;
          end
          IDX_STATUS: begin
            o_rdata[STAT_PULSE_BIT]          <= o_camera_trigger_pulse;
            o_rdata[STAT_FNUM_LSB +: 16]     <= frame_number;
          end
          default:             o_rresp      <= RESP_SLVERR;
        endcase
      end
    end
  end

  // sync generator: idle holds the start level; enabling enters the phase
  // matching that level, so the first phase is whole from the enable edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      gen_state              <= GEN_IDLE;
      period_cnt             <= '0;
      o_camera_trigger_pulse <= 1'b0;
    end else if (!ctrl.sync_generator_on) begin
      gen_state              <= GEN_IDLE;
      period_cnt             <= '0;
      o_camera_trigger_pulse <= ctrl.sync_start_level;
    end else begin
      case (gen_state)
        GEN_IDLE: begin
          if (ctrl.sync_start_level) begin
            gen_state  <= GEN_HIGH;
            period_cnt <= high_reload;
          end else begin
            gen_state  <= GEN_LOW;
            period_cnt <= low_reload;
          end
        end
        GEN_HIGH: begin
          o_camera_trigger_pulse <= 1'b1;
          if (period_cnt == '0) begin
            gen_state              <= GEN_LOW;
            period_cnt             <= low_reload;
            o_camera_trigger_pulse <= 1'b0;
          end else begin
            period_cnt <= period_cnt - 24'h000001;
          end
        end
        GEN_LOW: begin
          o_camera_trigger_pulse <= 1'b0;
          if (period_cnt == '0) begin
            gen_state              <= GEN_HIGH;
            period_cnt             <= high_reload;
            o_camera_trigger_pulse <= 1'b1;
          end else begin
            period_cnt <= period_cnt - 24'h000001;
          end
        end
        default: begin
          gen_state  <= GEN_IDLE;
          period_cnt <= '0;
        end
      endcase
    end
  end

  // frame number advances on each frame start and is held for the frame end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      frame_number <= '0;
    end else if (frame_limit == 16'h0000) begin
      frame_number <= '0;
    end else if (ctrl.raw_mode && i_frame_start) begin
      frame_number <= next_frame(frame_number, frame_limit);
    end
  end

  // tag is presented one cycle after each strobe, together with the number
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_frame_tag <= '0;
    end else begin
      o_frame_tag.start_strobe <= ctrl.raw_mode && i_frame_start;
      o_frame_tag.end_strobe   <= ctrl.raw_mode && i_frame_end;
      if (frame_limit == 16'h0000) begin
        o_frame_tag.number <= '0;
      end else if (ctrl.raw_mode && i_frame_start) begin
        o_frame_tag.number <= next_frame(frame_number, frame_limit);
      end else if (ctrl.raw_mode && i_frame_end) begin
        o_frame_tag.number <= frame_number;
      end
    end
  end

endmodule : fsfc_top

// file: fsfc_pkg.sv
// fsfc_pkg: register map, field layout, reset values and carrier types
// for the sync pulse generator and frame number counter.
// assumes a 32-bit axi4-lite slave, one register per aligned word.
package fsfc_pkg;

  // printed offsets are not multiples of four: they are word indices
  localparam logic [7:0] IDX_SYNC_HIGH_UPPER  = 8'h19;
  localparam logic [7:0] IDX_SYNC_HIGH_LOWER  = 8'h1a;
  localparam logic [7:0] IDX_SYNC_LOW_UPPER   = 8'h1b;
  localparam logic [7:0] IDX_SYNC_LOW_LOWER   = 8'h1c;
  localparam logic [7:0] IDX_FRAME_LIM_UPPER  = 8'h1d;
  localparam logic [7:0] IDX_FRAME_LIM_LOWER  = 8'h1e;
  localparam logic [7:0] IDX_SYNC_CTRL        = 8'h18;
  localparam logic [7:0] IDX_STATUS           = 8'h20;

  localparam logic [7:0] RST_SYNC_HIGH_UPPER  = 8'h00;
  localparam logic [7:0] RST_SYNC_HIGH_LOWER  = 8'h00;
  localparam logic [7:0] RST_SYNC_LOW_UPPER   = 8'h00;
  localparam logic [7:0] RST_SYNC_LOW_LOWER   = 8'h00;
  localparam logic [7:0] RST_FRAME_LIM_UPPER  = 8'h00;
  localparam logic [7:0] RST_FRAME_LIM_LOWER  = 8'h04;
  localparam logic [7:0] RST_SYNC_CTRL        = 8'h00;

  // control register fields
  localparam int CTRL_GEN_ON_BIT   = 0;
  localparam int CTRL_SHAPE_BIT    = 1;
  localparam int CTRL_START_BIT    = 2;
  localparam int CTRL_RAW_MODE_BIT = 3;

  // status register fields
  localparam int STAT_PULSE_BIT    = 0;
  localparam int STAT_FNUM_LSB     = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_HIGH = 2'b01,
    GEN_LOW  = 2'b11
  } fsfc_gen_state_type;

  typedef struct packed {
    logic        sync_generator_on;
    logic        sync_shape_select;
    logic        sync_start_level;
    logic        raw_mode;
  } fsfc_ctrl_type;

  typedef struct packed {
    logic [15:0] number;
    logic        start_strobe;
    logic        end_strobe;
  } fsfc_frame_tag_type;

endpackage : fsfc_pkg

// file: fsfc_top_assertions.sv
// checker: bus handshake timing and frame tag strobes of fsfc_top
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module fsfc_top_assertions
  import fsfc_pkg::*;
(
  input wire logic               i_ref_clk,
  input wire logic               i_rst,
  input wire logic               i_awvalid,
  input wire logic               o_awready,
  input wire logic               i_wvalid,
  input wire logic               o_wready,
  input wire logic [1:0]         o_bresp,
  input wire logic               o_bvalid,
  input wire logic               i_bready,
  input wire logic               i_arvalid,
  input wire logic               o_arready,
  input wire logic [31:0]        o_rdata,
  input wire logic               o_rvalid,
  input wire logic               i_rready,
  input wire logic               i_frame_start,
  input wire logic               i_frame_end,
  input wire fsfc_frame_tag_type o_frame_tag
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  sequence wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_taken;
    i_arvalid && o_arready;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 o_bvalid)
    else $error("write response late");
  chk_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (rd_taken |=> o_rvalid)
    else $error("read data late");
  chk_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  chk_rvalid_release: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read data not released");
  chk_ready_pulse: assert property (o_awready || o_wready |=> !o_awready && !o_wready)
    else $error("ready longer than one cycle");
  chk_tag_start: assert property (o_frame_tag.start_strobe |-> $past(i_frame_start))
    else $error("start tag without frame start");
  chk_tag_end: assert property (o_frame_tag.end_strobe |-> $past(i_frame_end))
    else $error("end tag without frame end");
endmodule : fsfc_top_assertions
bind fsfc_top fsfc_top_assertions chk_i (
  .i_ref_clk     (i_ref_clk),
  .i_rst         (i_rst),
  .i_awvalid     (i_awvalid),
  .o_awready     (o_awready),
  .i_wvalid      (i_wvalid),
  .o_wready      (o_wready),
  .o_bresp       (o_bresp),
  .o_bvalid      (o_bvalid),
  .i_bready      (i_bready),
  .i_arvalid     (i_arvalid),
  .o_arready     (o_arready),
  .o_rdata       (o_rdata),
  .o_rvalid      (o_rvalid),
  .i_rready      (i_rready),
  .i_frame_start (i_frame_start),
  .i_frame_end   (i_frame_end),
  .o_frame_tag   (o_frame_tag)
);

// file: fsfc_trigger_rx.sv
// trigger receiver model: measures each phase of the sync pulse in cycles
// assumes the pulse is sampled on the rising reference clock edge
`timescale 1ns/1ps
module fsfc_trigger_rx (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_level,
  output int        o_last_high,
  output int        o_last_low,
  output int        o_edges
);
  logic prev;
  int   run;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev    <= 1'b0;
      run     <= 0;
      o_edges <= 0;
    end else begin
      prev <= i_level;
      if (i_level != prev) begin
        o_edges <= o_edges + 1;
        run     <= 1;
        if (prev) o_last_high <= run;
        else o_last_low <= run;
      end else begin
        run <= run + 1;
      end
    end
  end
endmodule : fsfc_trigger_rx

// file: test_frame_sync_timing_and_frame_counter.sv
// testbench: registers, sync pulse timing and frame numbering of fsfc_top
// assumes the trigger receiver model and the bound checker are compiled
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_frame_sync_timing_and_frame_counter import fsfc_pkg::*;;
  logic               i_ref_clk = 1'b0, i_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic               i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic               i_frame_start = 1'b0, i_frame_end = 1'b0;
  logic [11:0]        i_awaddr = 12'h0, i_araddr = 12'h0;
  logic [31:0]        i_wdata = 32'h0, o_rdata, seed = 32'h439;
  logic [3:0]         i_wstrb = 4'hf;
  logic               o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic               o_camera_trigger_pulse;
  logic [1:0]         o_bresp, o_rresp;
  fsfc_frame_tag_type o_frame_tag;
  logic [7:0]         mem [6];
  int                 n_errors = 0, compares = 0, cycles = 0, hi_len, lo_len, edges;
  localparam logic [7:0] IDX [6] = '{IDX_SYNC_HIGH_UPPER, IDX_SYNC_HIGH_LOWER,
    IDX_SYNC_LOW_UPPER, IDX_SYNC_LOW_LOWER, IDX_FRAME_LIM_UPPER, IDX_FRAME_LIM_LOWER};
  localparam logic [7:0] RST_V [6] = '{RST_SYNC_HIGH_UPPER, RST_SYNC_HIGH_LOWER,
    RST_SYNC_LOW_UPPER, RST_SYNC_LOW_LOWER, RST_FRAME_LIM_UPPER, RST_FRAME_LIM_LOWER};

  fsfc_top fsfc_top_i (
    .i_ref_clk              (i_ref_clk),
    .i_rst                  (i_rst),
    .i_awaddr               (i_awaddr),
    .i_awvalid              (i_awvalid),
    .o_awready              (o_awready),
    .i_wdata                (i_wdata),
    .i_wstrb                (i_wstrb),
    .i_wvalid               (i_wvalid),
    .o_wready               (o_wready),
    .o_bresp                (o_bresp),
    .o_bvalid               (o_bvalid),
    .i_bready               (i_bready),
    .i_araddr               (i_araddr),
    .i_arvalid              (i_arvalid),
    .o_arready              (o_arready),
    .o_rdata                (o_rdata),
    .o_rresp                (o_rresp),
    .o_rvalid               (o_rvalid),
    .i_rready               (i_rready),
    .i_frame_start          (i_frame_start),
    .i_frame_end            (i_frame_end),
    .o_camera_trigger_pulse (o_camera_trigger_pulse),
    .o_frame_tag            (o_frame_tag)
  );
  fsfc_trigger_rx fsfc_trigger_rx_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_level(o_camera_trigger_pulse), .o_last_high(hi_len), .o_last_low(lo_len),
    .o_edges(edges));

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // the longest case is a 257-cycle high phase, so this ceiling is generous
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // bready may start low and rise once bvalid is seen, so the response must stand
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic [31:0] rnd;
    rnd = xs();
    @(posedge i_ref_clk);
    i_awaddr  <= {2'b00, idx, 2'b00};
    i_wdata   <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= rnd[0];
    do begin
      @(posedge i_ref_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1 && i_bready !== 1'b1) i_bready <= 1'b1;
    end while (!(o_bvalid === 1'b1 && i_bready === 1'b1));
    i_bready <= 1'b0;
    resp = o_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic [31:0] rnd;
    rnd = xs();
    @(posedge i_ref_clk);
    i_araddr  <= {2'b00, idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready  <= rnd[0];
    do begin
      @(posedge i_ref_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1 && i_rready !== 1'b1) i_rready <= 1'b1;
    end while (!(o_rvalid === 1'b1 && i_rready === 1'b1));
    i_rready <= 1'b0;
    d = o_rdata;
    resp = o_rresp;
  endtask : rd

  task automatic frame(inout int num, input int lim);
    @(posedge i_ref_clk);
    i_frame_start <= 1'b1;
    @(posedge i_ref_clk);
    i_frame_start <= 1'b0;
    i_frame_end   <= 1'b1;
    num = (lim == 0) ? 0 : (num == 0 || num >= lim) ? 1 : num + 1;
    @(negedge i_ref_clk);
    `CHK({o_frame_tag.start_strobe, o_frame_tag.number}, {1'b1, num[15:0]})
    @(posedge i_ref_clk);
    i_frame_end <= 1'b0;
    @(negedge i_ref_clk);
    `CHK({o_frame_tag.end_strobe, o_frame_tag.number}, {1'b1, num[15:0]})
  endtask : frame

  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    logic [7:0]  hu, hl, ll, ctl;
    int          e0, exh, num, lim;
    num = 0;
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rd(IDX[k], d, r);
      `CHK(d, {24'h0, RST_V[k]})
    end
    rd(8'h28, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(8'h28, 8'h5a, r);
    `CHK(r, RESP_SLVERR)
    for (int k = 0; k < 6; k++) begin
      v = xs();
      mem[k] = v[7:0];
      wr(IDX[k], mem[k], r);
    end
    for (int k = 0; k < 6; k++) begin
      rd(IDX[k], d, r);
      `CHK({r, d}, {RESP_OKAY, 24'h0, mem[k]})
    end
    // a write without the lane-0 strobe is answered but changes nothing
    i_wstrb <= 4'h0;
    wr(IDX_SYNC_HIGH_UPPER, ~mem[0], r);
    i_wstrb <= 4'hf;
    `CHK(r, RESP_OKAY)
    rd(IDX_SYNC_HIGH_UPPER, d, r);
    `CHK({r, d}, {RESP_OKAY, 24'h0, mem[0]})
    // case 2 leaves the high upper byte set: the shared period must ignore it
    for (int c = 0; c < 3; c++) begin
      v = xs();
      hu = {7'h0, c != 0};
      hl = (c == 0) ? {6'h0, v[1:0]} : 8'h00;
      ll = (c == 0) ? 8'h00 : {5'h0, v[4:2]};
      ctl = {5'h0, c != 0, c == 2, 1'b0};
      wr(IDX_SYNC_HIGH_UPPER, hu, r);
      wr(IDX_SYNC_HIGH_LOWER, hl, r);
      wr(IDX_SYNC_LOW_UPPER, 8'h00, r);
      wr(IDX_SYNC_LOW_LOWER, ll, r);
      wr(IDX_SYNC_CTRL, ctl, r);
      rd(IDX_SYNC_CTRL, d, r);
      `CHK({r, d}, {RESP_OKAY, 24'h0, ctl})
      rd(IDX_STATUS, d, r);
      `CHK({d[0], o_camera_trigger_pulse}, {2{ctl[2]}})
      e0 = edges;
      wr(IDX_SYNC_CTRL, ctl | 8'h01, r);
      while (edges < e0 + 3) @(posedge i_ref_clk);
      exh = (c == 2) ? ll + 1 : hu * 256 + hl + 1;
      @(negedge i_ref_clk);
      `CHK(hi_len, exh)
      `CHK(lo_len, ll + 1)
      wr(IDX_SYNC_CTRL, 8'h00, r);
    end
    v = xs();
    lim = 2 + v[1:0];
    wr(IDX_FRAME_LIM_UPPER, 8'h00, r);
    wr(IDX_FRAME_LIM_LOWER, lim[7:0], r);
    wr(IDX_SYNC_CTRL, 8'h08, r);
    rd(IDX_SYNC_CTRL, d, r);
    `CHK({r, d}, {RESP_OKAY, 32'h8})
    repeat (2 * lim + 1) frame(num, lim);
    rd(IDX_STATUS, d, r);
    `CHK(d[31:16], num[15:0])
    lim = 0;
    wr(IDX_FRAME_LIM_LOWER, 8'h00, r);
    repeat (2) frame(num, lim);
    `CHK(o_frame_tag.number, 16'h0)
    conclude();
  end
endmodule : test_frame_sync_timing_and_frame_counter
